// File: design/rse_pkg.sv
// Package with encodings, widths and reset values of the rotate/sleep unit.
package rse_pkg;
    // Instruction word width and operand widths.
    localparam int RSE_IW = 14;
    localparam int RSE_DW = 8;
    localparam int RSE_AW = 7;
    // Opcode field positions and values for the rotates.
    localparam int RSE_OPC_HI = 13;
    localparam int RSE_OPC_LO = 8;
    localparam int RSE_DEST_BIT = 7;
    localparam logic [5:0] RSE_OPC_ROT_LEFT = 6'h0D;
    localparam logic [5:0] RSE_OPC_ROT_RIGHT = 6'h0C;
    // The whole sleep word.
    localparam logic [13:0] RSE_SLEEP_WORD = 14'h0063;
    // Reset values of the state kept here.
    localparam logic [7:0] RSE_ACC_RESET = 8'h00;
    localparam logic RSE_CARRY_RESET = 1'b0;
    localparam logic RSE_EXPIRY_RESET = 1'b1;
    localparam logic RSE_SLEPT_RESET = 1'b1;
    localparam logic [7:0] RSE_WDOG_RESET = 8'h00;
    localparam logic [7:0] RSE_PRESC_RESET = 8'h00;
    // Kinds of decoded operation.
    typedef enum logic [1:0] {
        RSE_OP_NONE,
        RSE_OP_ROT_LEFT,
        RSE_OP_ROT_RIGHT,
        RSE_OP_SLEEP
    } rse_op_t;
endpackage

// File: design/rse_decode.sv
// Combinational decoder that classifies one instruction word.
`timescale 1ns/1ps
module rse_decode
    import rse_pkg::*;
(
    input wire logic [13:0] i_word,
    output rse_op_t o_op
);
    // Compare the opcode field, or the whole word for sleep.
    always_comb begin
        if (i_word[RSE_OPC_HI:RSE_OPC_LO] == RSE_OPC_ROT_LEFT) begin
            o_op = RSE_OP_ROT_LEFT;
        end else if (i_word[RSE_OPC_HI:RSE_OPC_LO] == RSE_OPC_ROT_RIGHT) begin
            o_op = RSE_OP_ROT_RIGHT;
        end else if (i_word == RSE_SLEEP_WORD) begin
            o_op = RSE_OP_SLEEP;
        end else begin
            // Any other word belongs to logic outside this block.
            o_op = RSE_OP_NONE;
        end
    end
endmodule

// File: design/rse_exec.sv
// Execution unit for the rotate-through-carry and sleep instructions.
//
// What this block does
// - Rotate left: carry into bit0, bit7 out.
// - Destination bit 0 to accumulator, 1 register.
// - Sleep clears the sleep-entered flag.
// - Sleep sets the expiry flag.
// - Sleep loads the watchdog counter with zero.
// - Sleep restarts the watchdog prescaler from zero.
// - After sleep, enter sleep, oscillator halted.
// - Sleep leaves carry, digit-carry, zero untouched.
`timescale 1ns/1ps
module rse_exec
    import rse_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire logic [13:0] i_word,
    input wire logic [7:0] i_reg_data,
    input wire logic i_wake,
    input wire logic i_wdog_tick,
    input wire logic i_presc_tick,
    output logic [7:0] o_acc,
    output logic o_carry,
    output logic o_reg_we,
    output logic [6:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_expiry_flag,
    output logic o_sleep_entered_flag,
    output logic [7:0] o_watchdog_counter,
    output logic [7:0] o_presc,
    output logic o_asleep,
    output logic o_osc_run
);
    // Operation of the word presented this cycle.
    rse_op_t op;
    // Result of a rotate, with the carry that falls out.
    logic [7:0] rot_result;
    logic rot_carry;
    // Next values of every register but o_osc_run, which follows next_asleep.
    logic [7:0] next_acc;
    logic next_carry;
    logic next_reg_we;
    logic [6:0] next_reg_addr;
    logic [7:0] next_reg_wdata;
    logic next_expiry;
    logic next_slept;
    logic [7:0] next_wdog;
    logic [7:0] next_presc;
    logic next_asleep;

    // The decoder is kept separate so that the rest of the core can reuse it.
    rse_decode rse_decode_inst (
        .i_word(i_word),
        .o_op(op)
    );

    // Rotate datapath; both directions pass through the carry flag.
    always_comb begin
        rot_result = i_reg_data;
        rot_carry = o_carry;
        case (op)
            RSE_OP_ROT_LEFT: begin
                rot_result = {i_reg_data[6:0], o_carry};
                rot_carry = i_reg_data[7];
            end
            RSE_OP_ROT_RIGHT: begin
                rot_result = {o_carry, i_reg_data[7:1]};
                rot_carry = i_reg_data[0];
            end
            default: begin
                rot_result = i_reg_data;
                rot_carry = o_carry;
            end
        endcase
    end

    // Next-state logic. While asleep, instructions are not executed since the
    // oscillator is stopped; only a wake request or a reset brings the core back.
    always_comb begin
        next_acc = o_acc;
        next_carry = o_carry;
        next_reg_we = 1'b0;
        next_reg_addr = o_reg_addr;
        next_reg_wdata = o_reg_wdata;
        next_expiry = o_expiry_flag;
        next_slept = o_sleep_entered_flag;
        next_wdog = o_watchdog_counter;
        next_presc = o_presc;
        next_asleep = o_asleep;
        if (o_asleep) begin
            // Wake-up policy lives outside; we only leave the sleep state.
            if (i_wake) begin
                next_asleep = 1'b0;
            end
        end else begin
            // Watchdog counts only while the oscillator runs here.
            if (i_presc_tick) begin
                next_presc = o_presc + 8'h01;
            end
            if (i_wdog_tick) begin
                next_wdog = o_watchdog_counter + 8'h01;
            end
            if (i_valid) begin
                case (op)
                    RSE_OP_ROT_LEFT, RSE_OP_ROT_RIGHT: begin
                        next_carry = rot_carry;
                        if (i_word[RSE_DEST_BIT]) begin
                            // Write back into the addressed register.
                            next_reg_we = 1'b1;
                            next_reg_addr = i_word[RSE_AW-1:0];
                            next_reg_wdata = rot_result;
                        end else begin
                            next_acc = rot_result;
                        end
                    end
                    RSE_OP_SLEEP: begin
                        // Carry is not touched here; other flags live
                        // outside and receive no write strobe.
                        next_slept = 1'b0;
                        next_expiry = 1'b1;
                        next_wdog = 8'h00;
                        next_presc = 8'h00;
                        next_asleep = 1'b1;
                    end
                    default: begin
                        // Not an instruction for this unit.
                        next_reg_we = 1'b0;
                    end
                endcase
            end
        end
    end

    // Register stage; all outputs come straight from these flops.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_acc <= RSE_ACC_RESET;
            o_carry <= RSE_CARRY_RESET;
            o_reg_we <= 1'b0;
            o_reg_addr <= 7'h00;
            o_reg_wdata <= 8'h00;
            o_expiry_flag <= RSE_EXPIRY_RESET;
            o_sleep_entered_flag <= RSE_SLEPT_RESET;
            o_watchdog_counter <= RSE_WDOG_RESET;
            o_presc <= RSE_PRESC_RESET;
            o_asleep <= 1'b0;
            o_osc_run <= 1'b1;
        end else begin
            o_acc <= next_acc;
            o_carry <= next_carry;
            o_reg_we <= next_reg_we;
            o_reg_addr <= next_reg_addr;
            o_reg_wdata <= next_reg_wdata;
            o_expiry_flag <= next_expiry;
            o_sleep_entered_flag <= next_slept;
            o_watchdog_counter <= next_wdog;
            o_presc <= next_presc;
            o_asleep <= next_asleep;
            o_osc_run <= !next_asleep;
        end
    end

    // Checks next to the logic.
    AST_ROL_ACC: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_ROT_LEFT && !i_word[7])
        |=> o_acc == {$past(i_reg_data[6:0]), $past(o_carry)})
        else $error("rotate left result wrong");
    AST_ROL_C: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_ROT_LEFT)
        |=> o_carry == $past(i_reg_data[7]))
        else $error("rotate left carry wrong");
    AST_ROR: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_ROT_RIGHT && i_word[7])
        |=> o_reg_we && o_reg_wdata == {$past(o_carry),
        $past(i_reg_data[7:1])} && o_carry == $past(i_reg_data[0]))
        else $error("rotate right result wrong");
    // A rotate right aimed at the accumulator must not touch the register.
    AST_ROR_ACC: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_ROT_RIGHT && !i_word[7])
        |=> !o_reg_we && o_acc == {$past(o_carry), $past(i_reg_data[7:1])})
        else $error("rotate right to accumulator wrong");
    AST_DEST: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_ROT_LEFT && !i_word[7])
        |=> !o_reg_we)
        else $error("rotate to accumulator wrote register");
    AST_SLEEP_FLAGS: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP)
        |=> !o_sleep_entered_flag && o_expiry_flag)
        else $error("sleep flags wrong");
    AST_SLEEP_TO: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP)
        |=> o_expiry_flag)
        else $error("expiry flag not set");
    AST_SLEEP_WDOG: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP)
        |=> o_watchdog_counter == 8'h00)
        else $error("watchdog not cleared");
    AST_SLEEP_PRESC: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP)
        |=> o_presc == 8'h00)
        else $error("prescaler not cleared");
    // A wake level seen in the first sleeping cycle may end sleep at once,
    // so the second cycle only has to stay halted when no wake came.
    AST_SLEEP_OSC: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP && !i_wake)
        |=> o_asleep && !o_osc_run ##1 ($past(i_wake) || !o_osc_run))
        else $error("oscillator not halted");
    // While asleep without a wake, acc and carry may not move and no register is written.
    AST_ASLEEP_HOLD: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (o_asleep && !i_wake)
        |=> o_asleep && $stable(o_acc) && $stable(o_carry) && !o_reg_we)
        else $error("state moved while asleep");
    AST_SLEEP_C: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_valid && !o_asleep && op == RSE_OP_SLEEP)
        |=> $stable(o_carry) && $stable(o_acc) && !o_reg_we)
        else $error("sleep changed carry");
endmodule

// File: verif/tb_rotate_and_sleep_exec.sv
// Self-checking bench for the rotate and sleep execution unit.
`timescale 1ns/1ps
module tb_rotate_and_sleep_exec;
    import rse_pkg::*;
    // Inputs, all given a value at time zero.
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic i_valid = 1'b0;
    logic [13:0] i_word = 14'h0000;
    logic [7:0] i_reg_data = 8'h00;
    logic i_wake = 1'b0;
    logic i_wdog_tick = 1'b0;
    logic i_presc_tick = 1'b0;
    logic [7:0] o_acc, o_reg_wdata, o_watchdog_counter, o_presc;
    logic [6:0] o_reg_addr;
    logic o_carry, o_reg_we, o_expiry_flag, o_sleep_entered_flag;
    logic o_asleep, o_osc_run;
    // Reference state kept by the bench.
    logic [7:0] m_acc, m_wdata, m_wdog, m_presc;
    logic [6:0] m_addr;
    logic m_carry, m_we, m_exp, m_slept, m_asleep;
    int failures = 0;
    int cmp_count = 0;
    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 i_clock = ~i_clock;
    rse_exec rse_exec_inst (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_valid(i_valid), .i_word(i_word), .i_reg_data(i_reg_data),
        .i_wake(i_wake), .i_wdog_tick(i_wdog_tick),
        .i_presc_tick(i_presc_tick), .o_acc(o_acc), .o_carry(o_carry),
        .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr),
        .o_reg_wdata(o_reg_wdata), .o_expiry_flag(o_expiry_flag),
        .o_sleep_entered_flag(o_sleep_entered_flag),
        .o_watchdog_counter(o_watchdog_counter), .o_presc(o_presc),
        .o_asleep(o_asleep), .o_osc_run(o_osc_run));
    // Rotate through carry; result is the new carry above the data byte.
    function automatic logic [8:0] rot(input logic [7:0] d, input logic c,
                                       input logic left);
        return left ? {d[7], d[6:0], c} : {d[0], c, d[7:1]};
    endfunction
    // Draws a word: mostly rotates, some sleeps, some unknown codes.
    function automatic logic [13:0] pick(input int unsigned k);
        case (k % 8)
            0, 1, 2: return {RSE_OPC_ROT_LEFT, k[15:8]};
            3, 4, 5: return {RSE_OPC_ROT_RIGHT, k[15:8]};
            6: return RSE_SLEEP_WORD;
            default: return k[29:16];
        endcase
    endfunction
    task automatic chk8(input string n, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        chk8(n, {7'h00, e}, {7'h00, g});
    endtask
    // Advances the reference by one edge, using what the unit sees now.
    task automatic model_edge;
        logic [8:0] r;
        r = rot(i_reg_data, m_carry, i_word[13:8] == RSE_OPC_ROT_LEFT);
        m_we = 1'b0;
        if (!i_resetn) begin
            {m_acc, m_wdata, m_wdog, m_presc, m_addr} = '0;
            {m_carry, m_exp, m_slept, m_asleep} = 4'h6;
        end else if (m_asleep) begin
            // Words and ticks are ignored; only the wake level counts.
            if (i_wake) m_asleep = 1'b0;
        end else begin
            m_wdog = m_wdog + 8'(i_wdog_tick);
            m_presc = m_presc + 8'(i_presc_tick);
            if (i_valid && i_word == RSE_SLEEP_WORD) begin
                // Sleep wins over a tick in the same cycle.
                {m_wdog, m_presc} = 16'h0000;
                {m_exp, m_slept, m_asleep} = 3'h5;
            end else if (i_valid && i_word[13:9] == 5'h06) begin
                m_carry = r[8];
                if (i_word[7]) begin
                    {m_we, m_addr, m_wdata} = {1'b1, i_word[6:0], r[7:0]};
                end else begin
                    m_acc = r[7:0];
                end
            end
        end
    endtask
    // One cycle: drive at the rising edge, check at the falling edge.
    task automatic step(input logic rn, v, input logic [13:0] w,
                        input logic [7:0] d, input logic wk, wt, pt);
        @(posedge i_clock);
        model_edge();
        i_resetn <= rn;
        i_valid <= v;
        i_word <= w;
        i_reg_data <= d;
        i_wake <= wk;
        i_wdog_tick <= wt;
        i_presc_tick <= pt;
        @(negedge i_clock);
        chk8("acc", m_acc, o_acc);
        chk1("carry", m_carry, o_carry);
        chk1("reg_we", m_we, o_reg_we);
        chk8("reg_addr", {1'b0, m_addr}, {1'b0, o_reg_addr});
        chk8("reg_wdata", m_wdata, o_reg_wdata);
        chk1("expiry", m_exp, o_expiry_flag);
        chk1("slept", m_slept, o_sleep_entered_flag);
        chk8("wdog", m_wdog, o_watchdog_counter);
        chk8("presc", m_presc, o_presc);
        chk1("asleep", m_asleep, o_asleep);
        chk1("osc_run", !m_asleep, o_osc_run);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("Checks %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence: reset, fixed corner cases, then random traffic.
    initial begin
        void'($urandom(63));
        {m_acc, m_wdata, m_wdog, m_presc, m_addr} = '0;
        {m_carry, m_we, m_exp, m_slept, m_asleep} = 5'h0C;
        repeat (5) step(1'b0, 1'b0, 14'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b1, 14'h0D05, 8'hE6, 1'b0, 1'b1, 1'b0);
        step(1'b1, 1'b1, 14'h0C85, 8'hE6, 1'b0, 1'b0, 1'b1);
        chk8("fixed acc", 8'hCC, o_acc);
        // Sleep with both ticks in the same cycle, then one ignored rotate word.
        step(1'b1, 1'b1, RSE_SLEEP_WORD, 8'h00, 1'b0, 1'b1, 1'b1);
        step(1'b1, 1'b1, 14'h0D85, 8'hFF, 1'b0, 1'b1, 1'b1);
        step(1'b1, 1'b0, 14'h0000, 8'h00, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 3000; i++) begin
            step(i != 1500, 1'($urandom), pick($urandom), 8'($urandom),
                 ($urandom % 4) == 0, 1'($urandom), 1'($urandom));
        end
        step(1'b1, 1'b0, 14'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
